// ===== logic/vcs_codec_serial_port.sv
`timescale 1ns/1ps
module vcs_codec_serial_port #(
   parameter int DIV_W = 8,
   parameter logic [7:0] TX_ADDR_A = 8'h11, // Arbitrary bus addresses
   parameter logic [7:0] TX_ADDR_B = 8'h22,
   parameter logic [7:0] RX_DATA_A = 8'h31,
   parameter logic [7:0] RX_CTRL_A = 8'h32,
   parameter logic [7:0] RX_DATA_B = 8'h41,
   parameter logic [7:0] RX_CTRL_B = 8'h42,
   parameter logic [2:0] TX_SLOT_A = 3'h1,
   parameter logic [2:0] TX_SLOT_B = 3'h2
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Register bus
   input wire vcs_pkg::vcs_axi_req_type axi_req,
   output vcs_pkg::vcs_axi_rsp_type axi_rsp,
   // Clock pins
   input wire logic crystal_select_pin,
   output logic osc_power_up,
   output logic clk_buffer_enable,
   output logic aux_clock_out_a,
   output logic aux_clock_out_b,
   // Reset pins
   input wire logic reset_input_low,
   output logic power_on_reset_out,
   // Serial mode pins
   input wire logic serial_mode_sel_zero,
   input wire logic multiproc_mode_pin,
   input wire logic serial_mode_reserved_pin,
   // Serial port
   input wire logic serial_bit_clock,
   input wire logic serial_in,
   output logic serial_out,
   output logic serial_out_oe_n,
   input wire logic frame_strobe_i,
   output logic frame_strobe_o,
   output logic frame_strobe_oe_n,
   input wire logic serial_select_line_i,
   output logic serial_select_line_o,
   output logic serial_select_line_oe_n,
   // Analog path selection
   input wire logic external_gain_select,
   output logic preamp_path_sel
);
   import vcs_pkg::*;

   // =============================================================
   // Declarations
   logic [7:0] frame_period_q;
   logic status_flag_q;
   logic [DIV_W-1:0] div_q [2];
   logic [15:0] adc_q;
   logic [15:0] dac_q;
   logic [15:0] creg_q [4];
   logic aw_held_q, w_held_q, bvalid_q, rvalid_q;
   logic [7:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic [1:0] bresp_q, rresp_q;
   logic [31:0] rdata_q;
   logic wr_fire;
   logic rst_pin_q, rst_entry;
   logic [7:0] por_cnt_q;
   logic por_q;
   logic bck_q, bck_rise;
   logic [7:0] gen_cnt_q;
   logic strobe_drv_q, strobe_en, strobe_now, strobe_prev_q, strobe_fall;
   logic sel_inv;
   logic [3:0] bit_cnt_q, cur_bit, nxt_bit;
   logic [2:0] slot_q, cur_slot, nxt_slot, tx_slot;
   logic mp_synced_q, ap_busy_q, ctrl_word_q;
   logic [15:0] isr_q, osr_q, word_in;
   logic [7:0] rxa_q;
   logic mp_tx_q, sel_o_q, sel_oe_n_q;
   logic rx_valid_q, rx_ctrl_q;
   logic [15:0] rx_word_q;
   logic [7:0] tx_addr, rx_data_addr, rx_ctrl_addr;

   // Byte-lane merge, used by every writable register
   function automatic logic [31:0] vcs_merge(input logic [31:0] old, input logic [31:0] nw,
                                            input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return res;
   endfunction

   // =============================================================
   // Clock source and analog path pins
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         osc_power_up <= 1'b0;
         clk_buffer_enable <= 1'b1;
         preamp_path_sel <= 1'b1;
      end else begin
         osc_power_up <= crystal_select_pin;
         clk_buffer_enable <= ~crystal_select_pin;
         preamp_path_sel <= ~external_gain_select;
      end
   end

   // =============================================================
   // Auxiliary clock dividers; a divisor below two acts as two
   // because the output cannot toggle faster than every clock
   logic [1:0] aux_q;
   generate
      for (genvar g = 0; g < 2; g++) begin : g_div
         logic [DIV_W-1:0] cnt_q;
         logic [DIV_W-1:0] lim;
         assign lim = (div_q[g] < DIV_W'(2)) ? DIV_W'(2) : div_q[g];
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               cnt_q <= '0;
               aux_q[g] <= 1'b0;
            end else begin
               if (cnt_q >= lim - DIV_W'(1)) begin
                  cnt_q <= '0;
               end else begin
                  cnt_q <= cnt_q + DIV_W'(1);
               end
               aux_q[g] <= (cnt_q < (lim >> 1));
            end
         end
      end
   endgenerate
   assign aux_clock_out_a = aux_q[0];
   assign aux_clock_out_b = aux_q[1];

   // =============================================================
   // Reset pin entry and power-on reset output
   assign rst_entry = rst_pin_q & ~reset_input_low;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rst_pin_q <= 1'b1;
         por_cnt_q <= 8'(VCS_POR_HOLD_CYC);
         por_q <= 1'b0;
      end else begin
         rst_pin_q <= reset_input_low;
         if (rst_entry || !reset_input_low) begin
            por_cnt_q <= 8'(VCS_POR_HOLD_CYC);
            por_q <= 1'b0;
         end else if (por_cnt_q != 8'h00) begin
            por_cnt_q <= por_cnt_q - 8'h01;
         end else begin
            por_q <= 1'b1;
         end
      end
   end
   assign power_on_reset_out = por_q;

   // =============================================================
   // Bit clock edge and frame strobe
   assign bck_rise = serial_bit_clock & ~bck_q;
   assign strobe_en = ~multiproc_mode_pin & serial_mode_sel_zero;
   assign strobe_now = strobe_en ? strobe_drv_q : frame_strobe_i;
   assign strobe_fall = bck_rise & strobe_prev_q & ~strobe_now;
   assign frame_strobe_o = strobe_drv_q;
   assign frame_strobe_oe_n = ~strobe_en;

   // Strobe generator: low for one bit time at each frame start
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bck_q <= 1'b0;
         gen_cnt_q <= 8'h00;
         strobe_drv_q <= 1'b1;
         strobe_prev_q <= 1'b1;
      end else begin
         bck_q <= serial_bit_clock;
         if (bck_rise) begin
            strobe_prev_q <= strobe_now;
            if (gen_cnt_q >= frame_period_q - 8'h01) begin
               gen_cnt_q <= 8'h00;
            end else begin
               gen_cnt_q <= gen_cnt_q + 8'h01;
            end
            strobe_drv_q <= ~strobe_en | (gen_cnt_q != 8'h00);
         end
      end
   end

   // =============================================================
   // Serial engine slot and bit position
   assign sel_inv = ~serial_select_line_i;
   assign tx_slot = serial_mode_sel_zero ? TX_SLOT_B : TX_SLOT_A;
   assign tx_addr = serial_mode_sel_zero ? TX_ADDR_B : TX_ADDR_A;
   assign rx_data_addr = serial_mode_sel_zero ? RX_DATA_B : RX_DATA_A;
   assign rx_ctrl_addr = serial_mode_sel_zero ? RX_CTRL_B : RX_CTRL_A;
   assign cur_bit = strobe_fall ? 4'h0 : bit_cnt_q;
   assign cur_slot = strobe_fall ? 3'h0 : slot_q;
   assign nxt_bit = cur_bit + 4'h1;
   assign nxt_slot = (cur_bit == 4'hf) ? cur_slot + 3'h1 : cur_slot;
   assign word_in = {isr_q[14:0], serial_in};

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bit_cnt_q <= 4'h0;
         slot_q <= 3'h0;
         mp_synced_q <= 1'b0;
         ap_busy_q <= 1'b0;
         ctrl_word_q <= 1'b0;
         isr_q <= 16'h0000;
         osr_q <= 16'h0000;
         rxa_q <= 8'h00;
         mp_tx_q <= 1'b0;
         sel_o_q <= 1'b1;
         sel_oe_n_q <= 1'b1;
         rx_valid_q <= 1'b0;
         rx_ctrl_q <= 1'b0;
         rx_word_q <= 16'h0000;
      end else begin
         rx_valid_q <= 1'b0;
         if (bck_rise) begin
            isr_q <= word_in;
            if (multiproc_mode_pin) begin
               // Time-division mode on the shared bus
               bit_cnt_q <= nxt_bit;
               slot_q <= nxt_slot;
               if (strobe_fall) begin
                  mp_synced_q <= 1'b1;
               end
               if (cur_bit < 4'h8) begin
                  rxa_q <= {sel_inv, rxa_q[7:1]};
               end
               if (cur_bit == 4'hf && cur_slot != tx_slot && (mp_synced_q || strobe_fall)) begin
                  rx_word_q <= word_in;
                  rx_ctrl_q <= (rxa_q == rx_ctrl_addr);
                  rx_valid_q <= (rxa_q == rx_ctrl_addr) | (rxa_q == rx_data_addr);
               end
               mp_tx_q <= (nxt_slot == tx_slot) & (mp_synced_q | strobe_fall);
               if (nxt_slot == tx_slot && nxt_bit == 4'h0) begin
                  osr_q <= adc_q;
               end else begin
                  osr_q <= {osr_q[14:0], 1'b0};
               end
               // Address goes out inverted, LSB first, then the line is released
               if ((nxt_slot == tx_slot) && (mp_synced_q || strobe_fall) && nxt_bit < 4'h8) begin
                  sel_o_q <= ~tx_addr[nxt_bit[2:0]];
                  sel_oe_n_q <= 1'b0;
               end else begin
                  sel_o_q <= 1'b1;
                  sel_oe_n_q <= 1'b1;
               end
               ap_busy_q <= 1'b0;
               ctrl_word_q <= 1'b0;
            end else begin
               // Active/passive mode: strobe fall opens one word each way
               mp_synced_q <= 1'b0;
               mp_tx_q <= 1'b0;
               sel_oe_n_q <= 1'b1;
               if (strobe_fall) begin
                  ap_busy_q <= 1'b1;
                  bit_cnt_q <= 4'h1;
                  osr_q <= adc_q;
                  ctrl_word_q <= sel_inv;
               end else if (ap_busy_q) begin
                  bit_cnt_q <= nxt_bit;
                  osr_q <= {osr_q[14:0], 1'b0};
                  ctrl_word_q <= ctrl_word_q | sel_inv;
                  if (bit_cnt_q == 4'hf) begin
                     ap_busy_q <= 1'b0;
                     rx_word_q <= word_in;
                     rx_ctrl_q <= ctrl_word_q | sel_inv;
                     rx_valid_q <= 1'b1;
                  end
               end else begin
                  ctrl_word_q <= 1'b0;
               end
            end
         end
      end
   end

   // Output pin: in active/passive mode the status flag replaces the sample for control words
   // and while idle with the select line low
   always_comb begin
      if (multiproc_mode_pin) begin
         serial_out = osr_q[15];
         serial_out_oe_n = ~mp_tx_q; // line shared with serial_in
      end else begin
         serial_out_oe_n = 1'b0;
         if (ctrl_word_q || (!ap_busy_q && sel_inv)) begin
            serial_out = status_flag_q;
         end else begin
            serial_out = osr_q[15];
         end
      end
   end
   assign serial_select_line_o = sel_o_q;
   assign serial_select_line_oe_n = sel_oe_n_q;

   // =============================================================
   // Received word store: data register or addressed control register
   always_ff @(posedge aclk) begin
      if (!aresetn || rst_entry) begin
         for (int i = 0; i < 4; i++) begin
            creg_q[i] <= VCS_CREG_RST;
         end
         dac_q <= VCS_SAMPLE_RST;
      end else if (rx_valid_q) begin
         if (rx_ctrl_q) begin
            creg_q[rx_word_q[VCS_CREG_SEL_MSB -: 2]] <= rx_word_q;
         end else begin
            dac_q <= rx_word_q;
         end
      end
   end

   // =============================================================
   // AXI4-Lite write channel: address and data taken in either order
   assign wr_fire = aw_held_q & w_held_q & ~bvalid_q;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_q <= 1'b0;
         w_held_q <= 1'b0;
         bvalid_q <= 1'b0;
         awaddr_q <= 8'h00;
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
         bresp_q <= VCS_RESP_OKAY;
      end else begin
         if (axi_req.awvalid && !aw_held_q && !bvalid_q) begin
            aw_held_q <= 1'b1;
            awaddr_q <= axi_req.awaddr;
         end
         if (axi_req.wvalid && !w_held_q && !bvalid_q) begin
            w_held_q <= 1'b1;
            wdata_q <= axi_req.wdata;
            wstrb_q <= axi_req.wstrb;
         end
         if (wr_fire) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            bvalid_q <= 1'b1;
            unique case (awaddr_q)
               VCS_ADDR_CTRL, VCS_ADDR_CLKDIV, VCS_ADDR_ADC: bresp_q <= VCS_RESP_OKAY;
               default: bresp_q <= VCS_RESP_SLVERR;
            endcase
         end else if (bvalid_q && axi_req.bready) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   // Writable registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         frame_period_q <= VCS_PERIOD_RST;
         status_flag_q <= 1'b0;
         div_q[0] <= DIV_W'(VCS_DIV_A_RST);
         div_q[1] <= DIV_W'(VCS_DIV_B_RST);
         adc_q <= VCS_SAMPLE_RST;
      end else if (wr_fire) begin
         unique case (awaddr_q)
            VCS_ADDR_CTRL: begin
               logic [31:0] m;
               m = vcs_merge({16'h0000, frame_period_q, 7'h00, status_flag_q}, wdata_q, wstrb_q);
               status_flag_q <= m[VCS_CTRL_FLAG_BIT];
               frame_period_q <= m[VCS_CTRL_PERIOD_LSB +: 8];
            end
            VCS_ADDR_CLKDIV: begin
               logic [31:0] m;
               m = vcs_merge({16'h0000, 8'(div_q[1]), 8'(div_q[0])}, wdata_q, wstrb_q);
               div_q[0] <= DIV_W'(m[VCS_DIV_A_LSB +: 8]);
               div_q[1] <= DIV_W'(m[VCS_DIV_B_LSB +: 8]);
            end
            VCS_ADDR_ADC: begin
               logic [31:0] m;
               m = vcs_merge({16'h0000, adc_q}, wdata_q, wstrb_q);
               adc_q <= m[15:0];
            end
            default: begin
            end
         endcase
      end
   end

   // =============================================================
   // AXI4-Lite read channel, answer one cycle after the address
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
         rresp_q <= VCS_RESP_OKAY;
      end else if (axi_req.arvalid && !rvalid_q) begin
         rvalid_q <= 1'b1;
         rresp_q <= VCS_RESP_OKAY;
         if (axi_req.araddr >= VCS_ADDR_CREG0 && axi_req.araddr <= VCS_ADDR_CREG3
             && axi_req.araddr[1:0] == 2'b00) begin
            rdata_q <= {16'h0000, creg_q[2'(8'(axi_req.araddr - VCS_ADDR_CREG0) >> 2)]};
         end else begin
            unique case (axi_req.araddr)
               VCS_ADDR_CTRL: rdata_q <= {16'h0000, frame_period_q, 7'h00, status_flag_q};
               VCS_ADDR_CLKDIV: rdata_q <= {16'h0000, 8'(div_q[1]), 8'(div_q[0])};
               // Status: a high reserved pin means the serial port is out of spec
               VCS_ADDR_STATUS: rdata_q <= {24'h00_0000, serial_mode_reserved_pin,
                  mp_synced_q, ap_busy_q, por_q, crystal_select_pin, external_gain_select,
                  serial_mode_sel_zero, multiproc_mode_pin};
               VCS_ADDR_DAC: rdata_q <= {16'h0000, dac_q};
               VCS_ADDR_ADC: rdata_q <= {16'h0000, adc_q};
               default: begin
                  rdata_q <= 32'h0000_0000;
                  rresp_q <= VCS_RESP_SLVERR;
               end
            endcase
         end
      end else if (rvalid_q && axi_req.rready) begin
         rvalid_q <= 1'b0;
      end
   end

   // Bus answer signals
   always_comb begin
      axi_rsp.awready = ~aw_held_q & ~bvalid_q;
      axi_rsp.wready = ~w_held_q & ~bvalid_q;
      axi_rsp.bvalid = bvalid_q;
      axi_rsp.bresp = bresp_q;
      axi_rsp.arready = ~rvalid_q;
      axi_rsp.rvalid = rvalid_q;
      axi_rsp.rdata = rdata_q;
      axi_rsp.rresp = rresp_q;
   end

endmodule

// ===== logic/vcs_pkg.sv
// =============================================================
// Shared constants and carriers of the codec serial port block
package vcs_pkg;

   // =============================================================
   // Register map (byte addresses, one aligned word each)
   localparam logic [7:0] VCS_ADDR_CTRL = 8'h00;
   localparam logic [7:0] VCS_ADDR_CLKDIV = 8'h04;
   localparam logic [7:0] VCS_ADDR_STATUS = 8'h08;
   localparam logic [7:0] VCS_ADDR_DAC = 8'h0c;
   localparam logic [7:0] VCS_ADDR_ADC = 8'h10;
   localparam logic [7:0] VCS_ADDR_CREG0 = 8'h14;
   localparam logic [7:0] VCS_ADDR_CREG3 = 8'h20;

   // Field positions
   localparam int VCS_CTRL_FLAG_BIT = 0;
   localparam int VCS_CTRL_PERIOD_LSB = 8;
   localparam int VCS_DIV_A_LSB = 0;
   localparam int VCS_DIV_B_LSB = 8;

   // Values after reset
   localparam logic [7:0] VCS_PERIOD_RST = 8'h20;
   localparam logic [7:0] VCS_DIV_A_RST = 8'h04;
   localparam logic [7:0] VCS_DIV_B_RST = 8'h02;
   localparam logic [15:0] VCS_CREG_RST = 16'h0000;
   localparam logic [15:0] VCS_SAMPLE_RST = 16'h0000;

   // Bus answers
   localparam logic [1:0] VCS_RESP_OKAY = 2'b00;
   localparam logic [1:0] VCS_RESP_SLVERR = 2'b10;

   // Serial word and address layout
   localparam int VCS_WORD_BITS = 16;
   localparam int VCS_ADDR_BITS = 8;
   localparam int VCS_SLOTS = 8;
   localparam int VCS_CREG_SEL_MSB = 15;

   // Timing: power-on reset output held low after a reset entry
   localparam int VCS_CLK_PERIOD_NS = 100;
   localparam int VCS_POR_HOLD_NS = 1000;
   localparam int VCS_POR_HOLD_CYC =
      (VCS_POR_HOLD_NS + VCS_CLK_PERIOD_NS - 1) / VCS_CLK_PERIOD_NS;

   // AXI4-Lite carriers
   typedef struct packed {
      logic awvalid;
      logic [7:0] awaddr;
      logic wvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bready;
      logic arvalid;
      logic [7:0] araddr;
      logic rready;
   } vcs_axi_req_type;

   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } vcs_axi_rsp_type;

endpackage

// ===== verification/vcs_codec_serial_port_assertions.sv
`timescale 1ns/1ps
// =============================================================
// Port watcher of the codec serial port
module vcs_codec_serial_port_assertions
   import vcs_pkg::*;
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Clock, reset and gain pins
   input wire logic crystal_select_pin,
   input wire logic osc_power_up,
   input wire logic clk_buffer_enable,
   input wire logic reset_input_low,
   input wire logic power_on_reset_out,
   input wire logic external_gain_select,
   input wire logic preamp_path_sel,
   // Serial port pins and register bus answer
   input wire logic serial_mode_sel_zero,
   input wire logic multiproc_mode_pin,
   input wire logic serial_out_oe_n,
   input wire logic frame_strobe_o,
   input wire logic frame_strobe_oe_n,
   input wire logic serial_select_line_oe_n,
   input wire vcs_pkg::vcs_axi_rsp_type axi_rsp
);
   logic [2:0] calm_q;
   logic [1:0] mode_q;

   // The select line direction is registered and trails the mode pins until the next bit clock rise, so judge directions once settled
   always_ff @(posedge aclk) begin
      mode_q <= {multiproc_mode_pin, serial_mode_sel_zero};
      if (!aresetn || mode_q != {multiproc_mode_pin, serial_mode_sel_zero}) begin
         calm_q <= 3'h0;
      end else if (calm_q != 3'h7) begin
         calm_q <= calm_q + 3'h1;
      end
   end

   default clocking dc @(posedge aclk); endclocking
   default disable iff (!aresetn);

   AST_OSC: assert property (
      $past(aresetn) |-> osc_power_up == $past(crystal_select_pin))
      else $error("oscillator enable off crystal select");
   AST_CLKBUF: assert property (osc_power_up != clk_buffer_enable)
      else $error("oscillator and input buffer both on or both off");
   AST_PREAMP: assert property (
      $past(aresetn) |-> preamp_path_sel == !$past(external_gain_select))
      else $error("preamp path off gain select");
   AST_POR_LOW: assert property ($fell(reset_input_low) |-> ##2 !power_on_reset_out)
      else $error("power-on reset output not low after reset entry");
   AST_POR_HOLD: assert property (
      $rose(power_on_reset_out) |-> $past(reset_input_low, 9))
      else $error("power-on reset output released early");
   AST_STROBE_DIR: assert property (
      calm_q == 3'h7 && !multiproc_mode_pin |-> frame_strobe_oe_n == !serial_mode_sel_zero)
      else $error("strobe direction wrong");
   AST_STROBE_MP: assert property (
      calm_q == 3'h7 && multiproc_mode_pin |-> frame_strobe_oe_n)
      else $error("strobe driven in multiprocessor mode");
   AST_OUT_ACTIVE: assert property (
      calm_q == 3'h7 && !multiproc_mode_pin |-> !serial_out_oe_n)
      else $error("serial output not driven");
   AST_SEL_IN: assert property (
      calm_q == 3'h7 && !multiproc_mode_pin |-> serial_select_line_oe_n)
      else $error("select line driven outside multiprocessor mode");
   AST_SEL_TX: assert property (
      $fell(serial_select_line_oe_n) |-> ##[0:1] (!serial_out_oe_n && multiproc_mode_pin))
      else $error("address sent outside own slot");

   COV_STROBE_OUT: cover property (!frame_strobe_oe_n && !frame_strobe_o);
   COV_ADDR_OUT: cover property (!serial_select_line_oe_n);
   COV_WRITE_DONE: cover property (axi_rsp.bvalid);
endmodule

bind vcs_codec_serial_port vcs_codec_serial_port_assertions chk_i (.*);

// ===== verification/vcs_codec_serial_port_tb.sv
`timescale 1ns/1ps
// =============================================================
// Bench of the codec serial port
module vcs_codec_serial_port_tb;
   import vcs_pkg::*;
   typedef struct packed {
      logic [15:0] w;
      logic s;
      logic [7:0] ra;
      logic [15:0] eo;
   } vcs_row_type;
   localparam logic [7:0] TXA [2] = '{8'h11, 8'h22};
   localparam logic [7:0] RXD [2] = '{8'h31, 8'h41};
   // Word, select level, landing register, serial output (flag bits for control)
   localparam vcs_row_type ROWS [4] = '{
      '{16'h1234, 1'b1, VCS_ADDR_DAC, 16'ha5c3}, '{16'h8001, 1'b1, VCS_ADDR_DAC, 16'ha5c3},
      '{16'h4abc, 1'b0, 8'h18, 16'h7fff}, '{16'hc05a, 1'b0, VCS_ADDR_CREG3, 16'h7fff}};
   logic aclk, aresetn, xsel, osc, bufen, auxa, auxb, rpin, por, sel0, mp, sclk;
   logic sin, sout, soe, fsi, fso, fsoe, sli, slo, sloe, egs, pre, saw, ps, psel, pdin, obs;
   vcs_axi_req_type rq;
   vcs_axi_rsp_type rs;
   logic [47:0] seen;
   logic [31:0] d;
   logic [1:0] r;
   int n_errors = 0, n_tests = 0, cyc = 0, ha, hb;

   // Shared wires: the driving device wins, the processor otherwise
   assign fsi = fsoe ? ps : fso;
   assign sli = sloe ? psel : slo;
   assign sin = (mp && !soe) ? sout : pdin;
   assign obs = mp ? sli : sout;

   initial begin
      aclk = 1'b0;
      forever #50 aclk = ~aclk;
   end

   vcs_codec_serial_port #(.TX_ADDR_A(TXA[0]), .TX_ADDR_B(TXA[1]), .RX_DATA_A(RXD[0]),
         .RX_DATA_B(RXD[1])) dut (
      .aclk(aclk), .aresetn(aresetn), .axi_req(rq), .axi_rsp(rs),
      .crystal_select_pin(xsel), .osc_power_up(osc), .clk_buffer_enable(bufen),
      .aux_clock_out_a(auxa), .aux_clock_out_b(auxb), .reset_input_low(rpin),
      .power_on_reset_out(por), .serial_mode_sel_zero(sel0), .multiproc_mode_pin(mp),
      .serial_mode_reserved_pin(1'b0),
      .serial_bit_clock(sclk), .serial_in(sin), .serial_out(sout), .serial_out_oe_n(soe),
      .frame_strobe_i(fsi), .frame_strobe_o(fso), .frame_strobe_oe_n(fsoe),
      .serial_select_line_i(sli), .serial_select_line_o(slo), .serial_select_line_oe_n(sloe),
      .external_gain_select(egs), .preamp_path_sel(pre));

   vcs_dsp_partner p (.aclk(aclk), .bck(sclk), .strobe(ps), .sel(psel), .din(pdin), .obs(obs));

   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // Write: address and data offered together, each dropped once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      logic ta, tw;
      ta = 1'b0;
      tw = 1'b0;
      @(posedge aclk);
      rq.awvalid <= 1'b1;
      rq.awaddr <= a;
      rq.wvalid <= 1'b1;
      rq.wdata <= v;
      rq.wstrb <= 4'hf;
      rq.bready <= 1'b1;
      while (!(ta && tw)) begin
         @(posedge aclk);
         if (!ta && rs.awready) begin
            ta = 1'b1;
            rq.awvalid <= 1'b0;
         end
         if (!tw && rs.wready) begin
            tw = 1'b1;
            rq.wvalid <= 1'b0;
         end
      end
      do @(posedge aclk); while (!rs.bvalid);
      rq.bready <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] e);
      @(posedge aclk);
      rq.arvalid <= 1'b1;
      rq.araddr <= a;
      rq.rready <= 1'b1;
      do @(posedge aclk); while (!rs.arready);
      rq.arvalid <= 1'b0;
      do @(posedge aclk); while (!rs.rvalid);
      v = rs.rdata;
      e = rs.rresp;
      rq.rready <= 1'b0;
   endtask

   task automatic results;
      if (n_errors == 0 && n_tests > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // Note any driven strobe pulse; a run takes about 1700 cycles
   always @(posedge aclk) begin
      if (!fsoe && !fso) saw <= 1'b1;
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_errors++;
         results();
      end
   end

   initial begin
      rq = '0;
      {aresetn, xsel, sel0, mp, egs, saw} = 6'h0;
      rpin = 1'b1;
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      xsel <= 1'b1;
      egs <= 1'b1;
      repeat (3) @(posedge aclk);
      chk("osc", {31'h0, osc}, 32'h1);
      chk("pre", {31'h0, pre}, 32'h0);
      wr(VCS_ADDR_ADC, 32'h0000a5c3);
      wr(VCS_ADDR_CTRL, 32'h00002001);
      foreach (ROWS[i]) begin
         p.run(16, ROWS[i].w, ROWS[i].s ? 8'h00 : 8'hff, ROWS[i].s, seen);
         d = {16'h0, seen[15:0] & (ROWS[i].s ? 16'hffff : 16'h7fff)};
         chk("dout", d, {16'h0, ROWS[i].eo});
         rd(ROWS[i].ra, d, r);
         chk("rx", d, {16'h0, ROWS[i].w});
      end
      // Select still low and no transfer: flag follows its register bit
      repeat (4) @(posedge aclk);
      chk("flag1", {31'h0, sout}, 32'h1);
      wr(VCS_ADDR_CTRL, 32'h00002000);
      repeat (2) @(posedge aclk);
      chk("flag0", {31'h0, sout}, 32'h0);
      rpin <= 1'b0;
      repeat (4) @(posedge aclk);
      rpin <= 1'b1;
      repeat (14) @(posedge aclk);
      rd(VCS_ADDR_CREG3, d, r);
      chk("creg", d, {16'h0, VCS_CREG_RST});
      rd(8'h40, d, r);
      chk("resp", {30'h0, r}, {30'h0, VCS_RESP_SLVERR});
      // Sixty cycles span whole periods of both divided clocks
      wr(VCS_ADDR_CLKDIV, 32'h00000306);
      repeat (20) @(posedge aclk);
      {ha, hb} = 0;
      repeat (60) begin
         @(posedge aclk);
         ha += auxa;
         hb += auxb;
      end
      chk("auxa", ha, 32'd30);
      chk("auxb", hb, 32'd20);
      sel0 <= 1'b1;
      p.run(40, 16'h0, 8'h00, 1'b1, seen);
      chk("strobe", {31'h0, saw}, 32'h1);
      mp <= 1'b1;
      for (int j = 0; j < 2; j++) begin
         sel0 <= j[0];
         p.run(48, 16'h1357 ^ j[15:0], RXD[j], 1'b1, seen);
         for (int b = 0; b < 8; b++) begin
            chk("txaddr", {31'h0, seen[32 - 16 * j - b]}, {31'h0, ~TXA[j][b]});
         end
         rd(VCS_ADDR_DAC, d, r);
         chk("mpdac", d, {16'h0, 16'h1357 ^ j[15:0]});
      end
      p.run(16, 16'hdead, 8'h55, 1'b1, seen);
      rd(VCS_ADDR_DAC, d, r);
      chk("nomatch", d, 32'h00001356);
      results();
   end
endmodule

// ===== verification/vcs_dsp_partner.sv
`timescale 1ns/1ps
// =============================================================
// Processor serial port on the far side
module vcs_dsp_partner #(
   parameter int HALF = 3
) (
   // Clock
   input wire logic aclk,
   // Serial pins as the processor drives them
   output logic bck,
   output logic strobe,
   output logic sel,
   output logic din,
   // Line observed at each bit clock fall
   input wire logic obs
);
   // Bit clock stands still low between bursts
   initial begin
      bck = 1'b0;
      strobe = 1'b1;
      sel = 1'b1;
      din = 1'b0;
   end

   // A burst of n rises; strobe low before rise 0 only, select carries ~a LSB first
   task automatic run(input int n, input logic [15:0] w, input logic [7:0] a,
         input logic s, output logic [47:0] seen);
      logic [47:0] sh;
      sh = '0;
      for (int k = 0; k < n; k++) begin
         @(posedge aclk);
         strobe <= (k != 0);
         din <= w[15 - k % 16];
         sel <= (k % 16 < 8) ? ~a[k % 16] : s;
         repeat (HALF) @(posedge aclk);
         bck <= 1'b1;
         repeat (HALF) @(posedge aclk);
         sh = {sh[46:0], obs};
         bck <= 1'b0;
      end
      @(posedge aclk);
      din <= ~din; // Released data shows no stale bit
      seen = sh;
   endtask
endmodule
